// [design/bfs_defs.svh]
`ifndef BFS_DEFS_SVH
`define BFS_DEFS_SVH

`define BFS_CLK_HZ 50000000
`define BFS_MS_PER_S 1000
`define BFS_EXT_SHORTEN_MS 10
`define BFS_DEBOUNCE_MS 2
`define BFS_DELAY_MIN_MS 16'h003C
`define BFS_DELAY_INF_MS 16'hFFFF

`define BFS_OFF_CTRL 12'h000
`define BFS_OFF_THRESH 12'h004
`define BFS_OFF_DELAY 12'h008
`define BFS_OFF_STATE 12'h00C
`define BFS_OFF_IRQ_STAT 12'h010
`define BFS_OFF_IRQ_CLR 12'h014
`define BFS_OFF_IRQ_EN 12'h018

`define BFS_CTRL_ENABLE 0
`define BFS_CTRL_AUX_CHECK 1
`define BFS_CTRL_ALLOC_LSB 2
`define BFS_CTRL_RESET 4'hC
`define BFS_THRESH_RESET 16'h0100
`define BFS_DELAY_RESET 16'h00FA

`define BFS_EV_INT_PICKUP 0
`define BFS_EV_EXT_PICKUP 1
`define BFS_EV_INT_TRIP 2
`define BFS_EV_EXT_TRIP 3
`define BFS_EV_W 4

`endif

// [design/bfs_pkg.sv]
package bfs_pkg;
    typedef enum logic [1:0] {
        BFS_ALLOC_BOTH,
        BFS_ALLOC_OPEN_ONLY,
        BFS_ALLOC_CLOSED_ONLY,
        BFS_ALLOC_NONE
    } bfs_alloc_t;

    typedef enum logic [1:0] {
        BFS_IDLE,
        BFS_TIMING,
        BFS_TRIPPED,
        BFS_DROPPED
    } bfs_state_t;
endpackage : bfs_pkg

// [design/bfs_top.sv]
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`include "bfs_defs.svh"
// Overview of operation
// - Internal and external sources, separate pickup/timer/trip.
// - One threshold and one delay serve both.
// - Any phase above threshold means current flows.
// - Current trips need current AND contact criterion.
// - Invalid contact feedback: current criterion alone.
// - Voltage trips judged by the auxiliary contact.
// - Four contact wiring allocations supported.
// - Contacts classify breaker closed or open, valid only.
// - Initiation raises alarm and starts delay timer.
// - Expiry with criteria met asserts backup trip.
// - Function switchable by setting, blockable by input.
// - Criterion lost at expiry drops pickup, no trip.
// - External initiation input is debounced.
// - External input must persist whole delay.
// - External start shortens delay by 10 ms.
// - Contact check plus voltage trip combines by OR.
module bfs_top #(
    parameter int CUR_W = 16,
    parameter int CYCLES_PER_MS = `BFS_CLK_HZ / `BFS_MS_PER_S,
    parameter int DEBOUNCE_CYCLES = `BFS_DEBOUNCE_MS * (`BFS_CLK_HZ / `BFS_MS_PER_S)
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [CUR_W-1:0] phase_a_current,
    input wire logic [CUR_W-1:0] phase_b_current,
    input wire logic [CUR_W-1:0] phase_c_current,
    input wire logic int_trip_start,
    input wire logic int_trip_voltage,
    input wire logic external_initiation_input,
    input wire logic block_input,
    input wire logic aux_open_contact,
    input wire logic aux_closed_contact,
    output logic int_pickup,
    output logic ext_pickup,
    output logic alarm,
    output logic int_backup_trip,
    output logic ext_backup_trip,
    output logic backup_trip,
    output logic func_active,
    output logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    function automatic logic [31:0] ms_to_cycles(input logic [15:0] ms);
        return 32'(ms * CYCLES_PER_MS);
    endfunction : ms_to_cycles

    logic [3:0] ctrl_reg, ctrl_next;
    logic [CUR_W-1:0] thresh_reg, thresh_next;
    logic [15:0] delay_reg, delay_next;
    logic [`BFS_EV_W-1:0] irq_stat_reg, irq_stat_next, irq_en_reg, irq_en_next;
    logic [31:0] prdata_reg, prdata_next;
    logic ext_deb_reg, ext_deb_next;
    logic [31:0] deb_cnt_reg, deb_cnt_next;
    bfs_pkg::bfs_state_t st_reg [2], st_next [2];
    logic [31:0] cnt_reg [2], cnt_next [2];

    logic setup, access, wr_en, addr_ok, run, cur_ok, aux_valid, aux_closed;
    logic [1:0] init, volt, crit, expire;
    logic [31:0] target [2];
    logic [`BFS_EV_W-1:0] events;
    bfs_pkg::bfs_alloc_t alloc;

    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_en = access && pwrite;
    assign addr_ok = paddr inside {`BFS_OFF_CTRL, `BFS_OFF_THRESH, `BFS_OFF_DELAY,
        `BFS_OFF_STATE, `BFS_OFF_IRQ_STAT, `BFS_OFF_IRQ_CLR, `BFS_OFF_IRQ_EN};
    assign pready = 1'b1;
    assign pslverr = access && !addr_ok;
    assign prdata = prdata_reg;

    assign alloc = bfs_pkg::bfs_alloc_t'(ctrl_reg[`BFS_CTRL_ALLOC_LSB +: 2]);
    assign run = ctrl_reg[`BFS_CTRL_ENABLE] && !block_input;
    assign func_active = run;

    // Shared threshold for all three phases.
    assign cur_ok = (phase_a_current > thresh_reg) || (phase_b_current > thresh_reg)
        || (phase_c_current > thresh_reg);

    // With both contacts wired, equal states mean an intermediate or faulty position.
    always_comb begin
        case (alloc)
            bfs_pkg::BFS_ALLOC_BOTH: begin
                aux_valid = aux_open_contact != aux_closed_contact;
                aux_closed = aux_closed_contact && !aux_open_contact;
            end
            bfs_pkg::BFS_ALLOC_OPEN_ONLY: begin
                aux_valid = 1'b1;
                aux_closed = !aux_open_contact;
            end
            bfs_pkg::BFS_ALLOC_CLOSED_ONLY: begin
                aux_valid = 1'b1;
                aux_closed = aux_closed_contact;
            end
            default: begin
                aux_valid = 1'b0;
                aux_closed = 1'b0;
            end
        endcase
    end

    assign init = {ext_deb_reg, int_trip_start};
    assign volt = {1'b0, int_trip_voltage};

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            if (!ctrl_reg[`BFS_CTRL_AUX_CHECK] || !aux_valid) begin
                crit[i] = cur_ok;
            end else if (volt[i]) begin
                crit[i] = cur_ok || aux_closed;
            end else begin
                crit[i] = cur_ok && aux_closed;
            end
        end
    end

    // The external timer is shortened to offset the residual time of the external start.
    assign target[0] = ms_to_cycles(delay_reg);
    assign target[1] = ms_to_cycles(delay_reg - 16'(`BFS_EXT_SHORTEN_MS));

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            expire[i] = (st_reg[i] == bfs_pkg::BFS_TIMING) && init[i]
                && (delay_reg != `BFS_DELAY_INF_MS) && (cnt_reg[i] >= target[i] - 32'h1);
        end
    end

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            st_next[i] = st_reg[i];
            cnt_next[i] = cnt_reg[i];
            case (st_reg[i])
                bfs_pkg::BFS_IDLE: begin
                    cnt_next[i] = 32'h0;
                    if (run && init[i]) begin
                        st_next[i] = bfs_pkg::BFS_TIMING;
                    end
                end
                bfs_pkg::BFS_TIMING: begin
                    if (!init[i]) begin
                        st_next[i] = bfs_pkg::BFS_IDLE;
                    end else if (expire[i]) begin
                        st_next[i] = crit[i] ? bfs_pkg::BFS_TRIPPED
                            : bfs_pkg::BFS_DROPPED;
                    end else begin
                        cnt_next[i] = cnt_reg[i] + 32'h1;
                    end
                end
                default: begin
                    if (!init[i]) begin
                        st_next[i] = bfs_pkg::BFS_IDLE;
                    end
                end
            endcase
            if (!run) begin
                st_next[i] = bfs_pkg::BFS_IDLE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < 2; i++) begin
                st_reg[i] <= bfs_pkg::BFS_IDLE;
                cnt_reg[i] <= 32'h0;
            end
        end else begin
            for (int i = 0; i < 2; i++) begin
                st_reg[i] <= st_next[i];
                cnt_reg[i] <= cnt_next[i];
            end
        end
    end

    assign int_pickup = st_reg[0] == bfs_pkg::BFS_TIMING;
    assign ext_pickup = st_reg[1] == bfs_pkg::BFS_TIMING;
    assign int_backup_trip = st_reg[0] == bfs_pkg::BFS_TRIPPED;
    assign ext_backup_trip = st_reg[1] == bfs_pkg::BFS_TRIPPED;
    assign backup_trip = int_backup_trip || ext_backup_trip;
    assign alarm = int_pickup || ext_pickup;

    // A level change must persist for the full window before it is believed.
    always_comb begin
        ext_deb_next = ext_deb_reg;
        deb_cnt_next = 32'h0;
        if (external_initiation_input != ext_deb_reg) begin
            if (deb_cnt_reg >= 32'(DEBOUNCE_CYCLES) - 32'h1) begin
                ext_deb_next = external_initiation_input;
            end else begin
                deb_cnt_next = deb_cnt_reg + 32'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_deb_reg <= 1'b0;
            deb_cnt_reg <= 32'h0;
        end else begin
            ext_deb_reg <= ext_deb_next;
            deb_cnt_reg <= deb_cnt_next;
        end
    end

    // Each bit marks the cycle in which its state is entered, so one start counts once.
    assign events = {st_next[1] == bfs_pkg::BFS_TRIPPED && !ext_backup_trip,
        st_next[0] == bfs_pkg::BFS_TRIPPED && !int_backup_trip,
        st_next[1] == bfs_pkg::BFS_TIMING && !ext_pickup,
        st_next[0] == bfs_pkg::BFS_TIMING && !int_pickup};
    assign irq = |(irq_stat_reg & irq_en_reg);

    // Delay writes below the minimum are raised to it so a trip can never be instant.
    always_comb begin
        ctrl_next = ctrl_reg;
        thresh_next = thresh_reg;
        delay_next = delay_reg;
        irq_en_next = irq_en_reg;
        irq_stat_next = irq_stat_reg;
        prdata_next = prdata_reg;
        if (wr_en) begin
            case (paddr)
                `BFS_OFF_CTRL: ctrl_next = pwdata[3:0];
                `BFS_OFF_THRESH: thresh_next = pwdata[CUR_W-1:0];
                `BFS_OFF_DELAY: delay_next = (pwdata[15:0] < `BFS_DELAY_MIN_MS)
                    ? `BFS_DELAY_MIN_MS : pwdata[15:0];
                `BFS_OFF_IRQ_CLR: irq_stat_next = irq_stat_reg & ~pwdata[`BFS_EV_W-1:0];
                `BFS_OFF_IRQ_EN: irq_en_next = pwdata[`BFS_EV_W-1:0];
                default: ;
            endcase
        end
        irq_stat_next = irq_stat_next | events;
        if (setup && !pwrite) begin
            case (paddr)
                `BFS_OFF_CTRL: prdata_next = {28'h0, ctrl_reg};
                `BFS_OFF_THRESH: prdata_next = 32'(thresh_reg);
                `BFS_OFF_DELAY: prdata_next = {16'h0, delay_reg};
                `BFS_OFF_STATE: prdata_next = {23'h0, aux_valid, cur_ok, ext_backup_trip,
                    int_backup_trip, ext_pickup, int_pickup, run,
                    block_input, !ctrl_reg[`BFS_CTRL_ENABLE]};
                `BFS_OFF_IRQ_STAT: prdata_next = {28'h0, irq_stat_reg};
                `BFS_OFF_IRQ_EN: prdata_next = {28'h0, irq_en_reg};
                default: prdata_next = 32'h0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `BFS_CTRL_RESET;
            thresh_reg <= CUR_W'(`BFS_THRESH_RESET);
            delay_reg <= `BFS_DELAY_RESET;
            irq_en_reg <= 4'h0;
            irq_stat_reg <= 4'h0;
            prdata_reg <= 32'h0;
        end else begin
            ctrl_reg <= ctrl_next;
            thresh_reg <= thresh_next;
            delay_reg <= delay_next;
            irq_en_reg <= irq_en_next;
            irq_stat_reg <= irq_stat_next;
            prdata_reg <= prdata_next;
        end
    end

    int_trip_cause_a: assert property ($rose(int_backup_trip)
        |-> $past(int_pickup) && $past(crit[0]))
        else $error("Internal backup trip without pickup and criterion.");
    ext_trip_cause_a: assert property ($rose(ext_backup_trip)
        |-> $past(ext_pickup) && $past(crit[1]))
        else $error("External backup trip without pickup and criterion.");
    crit_lost_a: assert property (expire[0] && !crit[0]
        |=> !int_backup_trip && !int_pickup)
        else $error("Internal trip issued although criterion was lost.");
    ext_persist_a: assert property (ext_pickup && !ext_deb_reg
        |=> !ext_pickup [*2] ##0 !ext_backup_trip)
        else $error("External pickup survived loss of its input.");
    off_quiet_a: assert property (!run |=> !alarm && !backup_trip)
        else $error("Pickup or trip while switched off or blocked.");
    alarm_start_a: assert property (run && int_trip_start && !int_pickup
        && !int_backup_trip && st_reg[0] == bfs_pkg::BFS_IDLE |=> alarm && int_pickup)
        else $error("Initiation did not raise the alarm.");
    aux_fallback_a: assert property (expire[0] && !aux_valid && !cur_ok
        |=> !int_backup_trip)
        else $error("Trip issued on invalid contacts without current.");
    expire_once_a: assert property (expire[0] |=> !expire[0] && !int_pickup)
        else $error("Timer expired twice for one start.");
    deb_stable_a: assert property ($changed(ext_deb_reg)
        |-> $past(external_initiation_input) == ext_deb_reg)
        else $error("Debounced input changed on a one-cycle glitch.");
    ext_short_a: assert property (ext_pickup
        |-> target[1] == target[0] - 32'(`BFS_EXT_SHORTEN_MS * CYCLES_PER_MS))
        else $error("External delay not shortened.");
    stat_set_a: assert property (|events
        |=> (irq_stat_reg & $past(events)) == $past(events))
        else $error("Status event lost to a simultaneous clear.");
endmodule : bfs_top

// [test/bfs_breaker_model.sv]
`timescale 1ns/1ps
module bfs_breaker_model #(
    parameter int CUR_W = 16,
    parameter int OPEN_CYCLES = 100
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic trip_cmd,
    input wire logic stuck,
    input wire logic contact_fault,
    input wire logic [CUR_W-1:0] load_current,
    output logic [CUR_W-1:0] phase_a_current,
    output logic [CUR_W-1:0] phase_b_current,
    output logic [CUR_W-1:0] phase_c_current,
    output logic aux_open_contact,
    output logic aux_closed_contact
);
    logic closed_reg;
    int open_cnt;
    // Recloses as soon as the command drops, so every run starts from a closed breaker.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            closed_reg <= 1'b1;
            open_cnt <= 0;
        end else if (!trip_cmd) begin
            closed_reg <= 1'b1;
            open_cnt <= 0;
        end else if (!stuck && open_cnt == OPEN_CYCLES) begin
            closed_reg <= 1'b0;
        end else begin
            open_cnt <= open_cnt + 1;
        end
    end
    assign phase_a_current = closed_reg ? load_current : '0;
    assign phase_b_current = closed_reg ? (load_current >> 1) : '0;
    assign phase_c_current = '0;
    // A contact fault leaves neither contact made, which reads as contradictory.
    assign aux_closed_contact = closed_reg && !contact_fault;
    assign aux_open_contact = !closed_reg && !contact_fault;
endmodule : bfs_breaker_model

// [test/breaker_failure_supervisor_tb_top.sv]
`timescale 1ns/1ps
`include "bfs_defs.svh"
module breaker_failure_supervisor_tb_top;
    localparam int CPM = 10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er, int_pickup, ext_pickup, alarm, irq, func_active;
    logic int_backup_trip, ext_backup_trip, backup_trip, aux_open, aux_closed;
    logic int_trip_start = 1'b0, int_trip_voltage = 1'b0, ext_in = 1'b0, block_input = 1'b0;
    logic stuck = 1'b1, contact_fault = 1'b0;
    logic [15:0] load_current = 16'h0200, ia, ib, ic;
    int miscompares = 0, checked = 0;
    logic [3:0] exp_alloc = 4'b0111;
    always #10 pclk = ~pclk;
    bfs_top #(.CYCLES_PER_MS(CPM), .DEBOUNCE_CYCLES(4)) i_bfs_top (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .phase_a_current(ia), .phase_b_current(ib), .phase_c_current(ic),
        .int_trip_start(int_trip_start), .int_trip_voltage(int_trip_voltage),
        .external_initiation_input(ext_in), .block_input(block_input),
        .aux_open_contact(aux_open), .aux_closed_contact(aux_closed), .int_pickup(int_pickup),
        .ext_pickup(ext_pickup), .alarm(alarm), .int_backup_trip(int_backup_trip),
        .ext_backup_trip(ext_backup_trip), .backup_trip(backup_trip),
        .func_active(func_active), .irq(irq));
    bfs_breaker_model i_bfs_breaker_model (.pclk(pclk), .presetn(presetn),
        .trip_cmd(int_trip_start | ext_in), .stuck(stuck), .contact_fault(contact_fault),
        .load_current(load_current), .phase_a_current(ia), .phase_b_current(ib),
        .phase_c_current(ic), .aux_open_contact(aux_open), .aux_closed_contact(aux_closed));
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_word
    task automatic chk_bit(input string nm, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_bit
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            miscompares++;
            conclude();
        end
    endtask : apb
    // Source 0 is a current trip, 1 a voltage trip, 2 the external input.
    task automatic run_trip(input int src, input logic e, input int len);
        int n;
        logic pk;
        n = 0;
        @(posedge pclk);
        if (src == 2) ext_in <= 1'b1;
        else int_trip_start <= 1'b1;
        int_trip_voltage <= (src == 1);
        do begin
            @(posedge pclk);
            #1 n++;
            pk = (src == 2) ? ext_pickup : int_pickup;
        end while (pk !== 1'b1 && n < 50);
        if (pk !== 1'b1) begin
            miscompares++;
            conclude();
        end
        chk_bit("alarm", 1'b1, alarm);
        n = 0;
        while (pk === 1'b1 && n < 2000) begin
            @(posedge pclk);
            #1 n++;
            pk = (src == 2) ? ext_pickup : int_pickup;
        end
        if (pk === 1'b1) begin
            miscompares++;
            conclude();
        end
        chk_word("pickup length", len, n);
        chk_bit("own trip", e, (src == 2) ? ext_backup_trip : int_backup_trip);
        chk_bit("other trip", 1'b0, (src == 2) ? int_backup_trip : ext_backup_trip);
        chk_bit("trip", e, backup_trip);
        @(posedge pclk);
        ext_in <= 1'b0;
        int_trip_start <= 1'b0;
        int_trip_voltage <= 1'b0;
        repeat (10) @(posedge pclk);
        #1 chk_bit("trip released", 1'b0, backup_trip);
        @(posedge pclk);
    endtask : run_trip
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `BFS_OFF_CTRL, 0);
        chk_word("ctrl", 32'h0000000C, rd);
        apb(0, `BFS_OFF_THRESH, 0);
        chk_word("threshold", 32'h00000100, rd);
        apb(0, `BFS_OFF_DELAY, 0);
        chk_word("delay", 32'h000000FA, rd);
        apb(0, 12'h020, 0);
        chk_bit("unmapped error", 1'b1, er);
        chk_word("unmapped data", 32'h00000000, rd);
        int_trip_start <= 1'b1;
        repeat (20) @(posedge pclk);
        #1 chk_bit("pickup while off", 1'b0, int_pickup);
        apb(1, `BFS_OFF_DELAY, 32'h00000010);
        apb(0, `BFS_OFF_DELAY, 0);
        chk_word("delay clamped", 32'h0000003C, rd);
        apb(1, `BFS_OFF_IRQ_EN, 32'h0000000F);
        apb(1, `BFS_OFF_CTRL, 32'h0000000D);
        block_input <= 1'b1;
        repeat (20) @(posedge pclk);
        #1 chk_bit("func active", 1'b0, func_active);
        chk_bit("pickup blocked", 1'b0, int_pickup);
        apb(0, `BFS_OFF_STATE, 0);
        chk_word("state blocked", 32'h00000082, rd);
        int_trip_start <= 1'b0;
        block_input <= 1'b0;
        $display("Test done: switching and blocking");
        run_trip(0, 1'b1, 60 * CPM);
        chk_bit("irq", 1'b1, irq);
        apb(0, `BFS_OFF_IRQ_STAT, 0);
        chk_word("status", 32'h00000005, rd);
        apb(1, `BFS_OFF_IRQ_CLR, 32'h0000000F);
        #1 chk_bit("irq cleared", 1'b0, irq);
        run_trip(2, 1'b1, 50 * CPM);
        apb(0, `BFS_OFF_IRQ_STAT, 0);
        chk_word("ext status", 32'h0000000A, rd);
        $display("Test done: stuck breaker");
        stuck <= 1'b0;
        run_trip(0, 1'b0, 60 * CPM);
        run_trip(2, 1'b0, 50 * CPM);
        $display("Test done: healthy breaker");
        stuck <= 1'b1;
        ext_in <= 1'b1;
        repeat (2) @(posedge pclk);
        ext_in <= 1'b0;
        repeat (10) @(posedge pclk);
        #1 chk_bit("glitch pickup", 1'b0, ext_pickup);
        @(posedge pclk);
        ext_in <= 1'b1;
        repeat (100) @(posedge pclk);
        #1 chk_bit("ext pickup", 1'b1, ext_pickup);
        @(posedge pclk);
        ext_in <= 1'b0;
        repeat (700) @(posedge pclk);
        #1 chk_bit("early drop trip", 1'b0, ext_backup_trip);
        chk_bit("early drop pickup", 1'b0, ext_pickup);
        $display("Test done: external input");
        apb(1, `BFS_OFF_CTRL, 32'h00000003);
        run_trip(0, 1'b1, 60 * CPM);
        contact_fault <= 1'b1;
        run_trip(0, 1'b1, 60 * CPM);
        contact_fault <= 1'b0;
        load_current <= 16'h0000;
        run_trip(0, 1'b0, 60 * CPM);
        for (int k = 0; k < 4; k++) begin
            apb(1, `BFS_OFF_CTRL, {28'h0000000, k[1:0], 2'b11});
            run_trip(1, exp_alloc[k], 60 * CPM);
        end
        $display("Test done: contact criteria");
        conclude();
    end
endmodule : breaker_failure_supervisor_tb_top
